// *** hdl/swr_defines.svh ***
// command codes and timing figures of the single-wire rom layer
// assumes a 20 MHz system clock; times are in microseconds
`ifndef SWR_DEFINES_SVH
`define SWR_DEFINES_SVH

`define SWR_CLK_MHZ 20

// rom function command codes
`define SWR_CMD_READ 8'h33
`define SWR_CMD_MATCH 8'h55
`define SWR_CMD_SKIP 8'hcc
`define SWR_CMD_SEARCH 8'hf0
`define SWR_CMD_OD_SKIP 8'h3c
`define SWR_CMD_OD_MATCH 8'h69

// identity layout
`define SWR_ID_BITS 64
`define SWR_CMD_BITS 8

// reset low time, regular and overdrive speed
`define SWR_T_RST_REG_US 480
`define SWR_T_RST_OD_US 48
// reset low up to which the short-reset check expects overdrive kept
`define SWR_T_OD_KEEP_US 80
// wait after reset release before presence
`define SWR_T_PDH_REG_US 30
`define SWR_T_PDH_OD_US 3
// presence low time
`define SWR_T_PDL_REG_US 120
`define SWR_T_PDL_OD_US 12
// write sample point and read-zero hold, from the slot's falling edge
`define SWR_T_SMP_REG_US 30
`define SWR_T_SMP_OD_US 3

`define SWR_RST_REG_CYC (`SWR_T_RST_REG_US * `SWR_CLK_MHZ)
`define SWR_RST_OD_CYC (`SWR_T_RST_OD_US * `SWR_CLK_MHZ)
`define SWR_OD_KEEP_CYC (`SWR_T_OD_KEEP_US * `SWR_CLK_MHZ)
`define SWR_PDH_REG_CYC (`SWR_T_PDH_REG_US * `SWR_CLK_MHZ)
`define SWR_PDH_OD_CYC (`SWR_T_PDH_OD_US * `SWR_CLK_MHZ)
`define SWR_PDL_REG_CYC (`SWR_T_PDL_REG_US * `SWR_CLK_MHZ)
`define SWR_PDL_OD_CYC (`SWR_T_PDL_OD_US * `SWR_CLK_MHZ)
`define SWR_SMP_REG_CYC (`SWR_T_SMP_REG_US * `SWR_CLK_MHZ)
`define SWR_SMP_OD_CYC (`SWR_T_SMP_OD_US * `SWR_CLK_MHZ)

`endif

// *** hdl/swr_pkg.sv ***
// types shared by the single-wire rom layer and its bench
// no assumptions beyond a single clock domain
package swr_pkg;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_PDH = 2'b01,
        LK_PDL = 2'b10
    } swr_link_t;

    typedef enum logic [2:0] {
        RS_WAIT = 3'b000,
        RS_CMD = 3'b001,
        RS_READ = 3'b010,
        RS_MATCH = 3'b011,
        RS_SRCH = 3'b100,
        RS_DATA = 3'b101
    } swr_rom_t;

    // one byte of the memory phase; first marks the memory command byte
    typedef struct packed {
        logic first;
        logic [7:0] data;
    } swr_byte_t;

endpackage : swr_pkg

// *** hdl/swr_buf.sv ***
// small fifo between the line receiver and the memory layer
// depth must be a power of two; read data come from the storage register
`timescale 1ns/1ps
module swr_buf #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_ff[rd_ptr_ff];

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : swr_buf

// *** hdl/swr_rom_layer.sv ***
// slave network layer of a single-wire open-drain bus device
// line input is synchronous to sys_clk_i; an outside pad resolves dq_o/dq_oe_o
// What the device does; counter, scratchpad, crc and copy items are left to the memory layer
// - device is always slave, never initiates
// - slots begin at master falling edge
// - line only pulled low or released
// - regular and overdrive bit rates supported
// - line idles high; long low resets
// - init, rom command, memory command, data
// - reset pulse answered by presence pulse
// - rom commands are eight bits
// - read rom sends 64-bit identity
// - match rom: only exact identity continues
// - skip rom goes straight to memory
// - simultaneous senders give wired-and line
// - search: bit, complement, then master bit
// - overdrive skip sets overdrive flag
// - reset of 480 us clears overdrive
// - overdrive match sets flag on match
// - overdrive match miss restores earlier speed
// - counter read bytes streamed from memory
// - scratchpad read bytes streamed in order
// - write crc bytes sent on reads
// - copy authorization echoed then response
// - short reset keeps overdrive
`timescale 1ns/1ps
`include "swr_defines.svh"
module swr_rom_layer #(
    // identity: family code low byte, serial, crc high byte; value arbitrary
    parameter logic [63:0] ROM_ID = 64'h3c00_0012_3456_789a,
    parameter int RST_CYC = `SWR_RST_REG_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic dq_i,
    output logic dq_o,
    output logic dq_oe_o,
    output logic overdrive_o,
    output logic bus_reset_o,
    output logic mem_start_o,
    output logic rx_overrun_o,
    output swr_pkg::swr_byte_t rx_byte_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o
);
    import swr_pkg::*;

    localparam logic [13:0] RST_REG = 14'(RST_CYC);
    localparam logic [13:0] RST_OD = 14'(`SWR_RST_OD_CYC);
    localparam logic [13:0] OD_KEEP = 14'(`SWR_OD_KEEP_CYC);
    localparam logic [13:0] PDH_REG = 14'(`SWR_PDH_REG_CYC);
    localparam logic [13:0] PDH_OD = 14'(`SWR_PDH_OD_CYC);
    localparam logic [13:0] PDL_REG = 14'(`SWR_PDL_REG_CYC);
    localparam logic [13:0] PDL_OD = 14'(`SWR_PDL_OD_CYC);
    localparam logic [13:0] SMP_REG = 14'(`SWR_SMP_REG_CYC);
    localparam logic [13:0] SMP_OD = 14'(`SWR_SMP_OD_CYC);
    localparam logic [6:0] ID_LAST = 7'(`SWR_ID_BITS - 1);
    localparam logic [6:0] CMD_LAST = 7'(`SWR_CMD_BITS - 1);

    swr_link_t lk_ff;
    swr_rom_t rs_ff;
    logic line_prev_ff;
    logic [13:0] low_cnt_ff;
    logic [13:0] tmr_ff;
    logic [13:0] slot_cnt_ff;
    logic slot_act_ff;
    logic slot_tx_ff;
    logic slot_bit_ff;
    logic drive_rd_ff;
    logic od_ff;
    logic od_prev_ff;
    logic cmd_od_ff;
    logic mism_ff;
    logic [6:0] bit_cnt_ff;
    logic [1:0] step_ff;
    logic [7:0] sh_ff;
    logic mem_start_ff;
    logic txl_ff;
    logic [7:0] txsh_ff;
    logic [2:0] txcnt_ff;
    logic [7:0] rxsh_ff;
    logic [2:0] rxcnt_ff;
    logic rx_first_ff;
    logic overrun_ff;

    logic fall;
    logic rst_det;
    logic long_rst;
    logic bit_ev;
    logic bit_val;
    logic cur_tx;
    logic cur_bit;
    logic id_bit;
    logic [13:0] smp_cyc;
    logic cmd_done;
    logic [7:0] cmd_code;
    logic match_end;
    logic match_ok;
    logic srch_miss;
    logic rx_done;
    logic buf_in_ready;
    swr_byte_t buf_in;

    ////////////////////////////////////////////////////////////////////////////
    // line sensing

    assign fall = line_prev_ff && !dq_i;
    assign smp_cyc = od_ff ? SMP_OD : SMP_REG;
    assign rst_det = !line_prev_ff && dq_i && (low_cnt_ff >= (od_ff ? RST_OD : RST_REG));
    assign long_rst = low_cnt_ff >= RST_REG;
    assign bit_ev = slot_act_ff && (slot_cnt_ff == smp_cyc - 14'h0001);
    assign bit_val = slot_tx_ff ? slot_bit_ff : dq_i;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            line_prev_ff <= 1'b1;
            low_cnt_ff <= '0;
        end else begin
            line_prev_ff <= dq_i;
            if (dq_i) begin
                low_cnt_ff <= '0;
            end else if (low_cnt_ff != 14'h3fff) begin
                low_cnt_ff <= low_cnt_ff + 14'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset and presence

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            lk_ff <= LK_IDLE;
            tmr_ff <= '0;
        end else begin
            case (lk_ff)
                LK_IDLE: begin
                    tmr_ff <= '0;
                    if (rst_det) begin
                        lk_ff <= LK_PDH;
                    end
                end
                LK_PDH: begin
                    tmr_ff <= tmr_ff + 14'h0001;
                    if (tmr_ff == (od_ff ? PDH_OD : PDH_REG) - 14'h0001) begin
                        lk_ff <= LK_PDL;
                        tmr_ff <= '0;
                    end
                end
                LK_PDL: begin
                    tmr_ff <= tmr_ff + 14'h0001;
                    if (tmr_ff == (od_ff ? PDL_OD : PDL_REG) - 14'h0001) begin
                        lk_ff <= LK_IDLE;
                        tmr_ff <= '0;
                    end
                end
                default: begin
                    lk_ff <= LK_IDLE;
                    tmr_ff <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit slots

    // slots only start from a master edge; the device never opens one itself
    // slave only
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            slot_act_ff <= 1'b0;
            slot_cnt_ff <= '0;
            slot_tx_ff <= 1'b0;
            slot_bit_ff <= 1'b1;
            drive_rd_ff <= 1'b0;
        end else if (rst_det || bit_ev) begin
            slot_act_ff <= 1'b0;
            slot_cnt_ff <= '0;
            drive_rd_ff <= 1'b0;
        end else if (fall && !slot_act_ff && lk_ff == LK_IDLE) begin
            slot_act_ff <= 1'b1;
            slot_cnt_ff <= '0;
            slot_tx_ff <= cur_tx;
            slot_bit_ff <= cur_bit;
            drive_rd_ff <= cur_tx && !cur_bit;
        end else if (slot_act_ff) begin
            slot_cnt_ff <= slot_cnt_ff + 14'h0001;
        end
    end

    assign dq_o = 1'b0;
    assign dq_oe_o = drive_rd_ff || (lk_ff == LK_PDL);

    ////////////////////////////////////////////////////////////////////////////
    // rom functions

    assign id_bit = ROM_ID[bit_cnt_ff[5:0]];
    assign cmd_done = (rs_ff == RS_CMD) && bit_ev && (bit_cnt_ff == CMD_LAST);
    assign cmd_code = {bit_val, sh_ff[7:1]};
    assign match_end = (rs_ff == RS_MATCH) && bit_ev && (bit_cnt_ff == ID_LAST);
    assign match_ok = !mism_ff && (bit_val == id_bit);
    assign srch_miss = (rs_ff == RS_SRCH) && bit_ev && (step_ff == 2'd2) && (bit_val != id_bit);

    always_comb begin
        cur_tx = 1'b0;
        cur_bit = 1'b1;
        case (rs_ff)
            RS_READ: begin
                cur_tx = 1'b1;
                cur_bit = id_bit;
            end
            RS_SRCH: begin
                cur_tx = (step_ff != 2'd2);
                cur_bit = (step_ff == 2'd0) ? id_bit : !id_bit;
            end
            RS_DATA: begin
                cur_tx = txl_ff;
                cur_bit = txsh_ff[0];
            end
            default: begin
                cur_tx = 1'b0;
                cur_bit = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rs_ff <= RS_WAIT;
            bit_cnt_ff <= '0;
            step_ff <= '0;
            sh_ff <= '0;
            mism_ff <= 1'b0;
            cmd_od_ff <= 1'b0;
            mem_start_ff <= 1'b0;
        end else begin
            mem_start_ff <= 1'b0;
            if (rst_det) begin
                rs_ff <= RS_CMD;
                bit_cnt_ff <= '0;
                step_ff <= '0;
                mism_ff <= 1'b0;
                cmd_od_ff <= 1'b0;
            end else if (bit_ev) begin
                case (rs_ff)
                    RS_CMD: begin
                        sh_ff <= cmd_code;
                        bit_cnt_ff <= bit_cnt_ff + 7'd1;
                        if (bit_cnt_ff == CMD_LAST) begin
                            bit_cnt_ff <= '0;
                            case (cmd_code)
                                `SWR_CMD_READ: rs_ff <= RS_READ;
                                `SWR_CMD_MATCH: rs_ff <= RS_MATCH;
                                `SWR_CMD_OD_MATCH: begin
                                    rs_ff <= RS_MATCH;
                                    cmd_od_ff <= 1'b1;
                                end
                                `SWR_CMD_SEARCH: rs_ff <= RS_SRCH;
                                `SWR_CMD_SKIP, `SWR_CMD_OD_SKIP: begin
                                    rs_ff <= RS_DATA;
                                    mem_start_ff <= 1'b1;
                                end
                                default: rs_ff <= RS_WAIT;
                            endcase
                        end
                    end
                    RS_READ: begin
                        bit_cnt_ff <= bit_cnt_ff + 7'd1;
                        if (bit_cnt_ff == ID_LAST) begin
                            rs_ff <= RS_DATA;
                            mem_start_ff <= 1'b1;
                        end
                    end
                    RS_MATCH: begin
                        bit_cnt_ff <= bit_cnt_ff + 7'd1;
                        mism_ff <= !match_ok;
                        if (bit_cnt_ff == ID_LAST) begin
                            rs_ff <= match_ok ? RS_DATA : RS_WAIT;
                            mem_start_ff <= match_ok;
                        end
                    end
                    RS_SRCH: begin
                        step_ff <= step_ff + 2'd1;
                        if (srch_miss) begin
                            rs_ff <= RS_WAIT;
                        end else if (step_ff == 2'd2) begin
                            step_ff <= '0;
                            bit_cnt_ff <= bit_cnt_ff + 7'd1;
                            if (bit_cnt_ff == ID_LAST) begin
                                rs_ff <= RS_DATA;
                                mem_start_ff <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        rs_ff <= rs_ff;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // overdrive flag

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            od_ff <= 1'b0;
            od_prev_ff <= 1'b0;
        end else if (rst_det) begin
            if (long_rst) begin
                od_ff <= 1'b0;
            end
        end else if (cmd_done && cmd_code == `SWR_CMD_OD_SKIP) begin
            od_ff <= 1'b1;
        end else if (cmd_done && cmd_code == `SWR_CMD_OD_MATCH) begin
            od_prev_ff <= od_ff;
            od_ff <= 1'b1;
        end else if (match_end && cmd_od_ff && !match_ok) begin
            od_ff <= od_prev_ff;
        end
    end

    assign overdrive_o = od_ff;
    assign bus_reset_o = rst_det;
    assign mem_start_o = mem_start_ff;

    ////////////////////////////////////////////////////////////////////////////
    // memory phase byte streams

    assign tx_ready_o = (rs_ff == RS_DATA) && !txl_ff;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || rst_det) begin
            txl_ff <= 1'b0;
            txsh_ff <= '0;
            txcnt_ff <= '0;
        end else if (tx_valid_i && tx_ready_o) begin
            txl_ff <= 1'b1;
            txsh_ff <= tx_data_i;
            txcnt_ff <= '0;
        end else if (bit_ev && slot_tx_ff && rs_ff == RS_DATA) begin
            txsh_ff <= {1'b1, txsh_ff[7:1]};
            txcnt_ff <= txcnt_ff + 3'd1;
            if (txcnt_ff == 3'd7) begin
                txl_ff <= 1'b0;
            end
        end
    end

    assign rx_done = bit_ev && !slot_tx_ff && (rs_ff == RS_DATA) && (rxcnt_ff == 3'd7);
    assign buf_in = '{first: rx_first_ff, data: {bit_val, rxsh_ff[7:1]}};

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || rst_det) begin
            rxsh_ff <= '0;
            rxcnt_ff <= '0;
            rx_first_ff <= 1'b1;
        end else if (bit_ev && !slot_tx_ff && rs_ff == RS_DATA) begin
            rxsh_ff <= {bit_val, rxsh_ff[7:1]};
            rxcnt_ff <= rxcnt_ff + 3'd1;
            if (rxcnt_ff == 3'd7) begin
                rx_first_ff <= 1'b0;
            end
        end
    end

    // the master cannot be stalled, so a full buffer can only flag the loss
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || rst_det) begin
            overrun_ff <= 1'b0;
        end else if (rx_done && !buf_in_ready) begin
            overrun_ff <= 1'b1;
        end
    end

    assign rx_overrun_o = overrun_ff;

    swr_buf #(
        .WIDTH(9),
        .DEPTH(2)
    ) u_rx_buf (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .in_data_i(buf_in),
        .in_valid_i(rx_done),
        .in_ready_o(buf_in_ready),
        .out_data_o(rx_byte_o),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_presence;
        (lk_ff == LK_PDH) ##[1:700] (lk_ff == LK_PDL);
    endsequence

    sequence s_to_data;
        (rs_ff == RS_DATA) && mem_start_o;
    endsequence

    AST_PRESENCE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rst_det |=> s_presence) else $error("no presence after reset");
    AST_SLAVE_DRIVE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        dq_oe_o |-> (lk_ff == LK_PDL || slot_act_ff)) else $error("drive outside slot");
    AST_EDGE_SYNC: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(drive_rd_ff) |-> $past(fall)) else $error("read drive without edge");
    AST_OD_SKIP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cmd_done && cmd_code == `SWR_CMD_OD_SKIP) |=> (overdrive_o and s_to_data))
        else $error("overdrive skip failed");
    AST_LONG_RST: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (rst_det && long_rst) |=> !overdrive_o) else $error("overdrive kept on long reset");
    AST_SHORT_RST: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (rst_det && overdrive_o && low_cnt_ff <= OD_KEEP) |=> overdrive_o)
        else $error("overdrive lost on short reset");
    AST_MATCH_MISS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (match_end && !match_ok) |=> (rs_ff == RS_WAIT) && !mem_start_o)
        else $error("mismatch not dropped");
    AST_SKIP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cmd_done && cmd_code == `SWR_CMD_SKIP) |=> s_to_data) else $error("skip failed");
    AST_SRCH_MISS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        srch_miss |=> (rs_ff == RS_WAIT)) else $error("search mismatch kept");
    AST_ODM_MISS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (match_end && cmd_od_ff && !match_ok) |=> overdrive_o == $past(od_prev_ff))
        else $error("speed not restored");
    AST_LSB_FIRST: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (bit_ev && slot_tx_ff && rs_ff == RS_DATA) |-> slot_bit_ff == txsh_ff[0])
        else $error("tx bit order wrong");

endmodule : swr_rom_layer

// *** sim/swr_master_model.sv ***
// bus master model driving the single shared line of the rom layer
// assumes one device on the line and a pull-up when nobody pulls
`timescale 1ns/1ps
module swr_master_model (
    input wire logic sys_clk_i,
    input wire logic dev_pull_i,
    output logic line_o
);
    logic pull = 1'b0;
    logic fast = 1'b0;
    ////////////////////////////////////////
    // wired-and, pull-up when idle
    assign line_o = !(pull || dev_pull_i);
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : wt
    // slot opens with a fall, idles high
    task automatic low(input int n, input int gap);
        pull = 1'b1;
        wt(n);
        pull = 1'b0;
        wt(gap);
    endtask : low
    task automatic rst(input int n, output logic seen);
        low(n, fast ? 150 : 1500);
        seen = !line_o;
        wt(fast ? 250 : 1700);
    endtask : rst
    // zero holds past the sample point
    // regular zero stays under the overdrive reset length: the speed may switch mid-slot
    task automatic wbit(input logic b);
        if (fast) low(b ? 10 : 70, b ? 70 : 10);
        else low(b ? 100 : 700, b ? 700 : 100);
    endtask : wbit
    task automatic rbit(output logic b);
        low(2, fast ? 30 : 300);
        b = line_o;
        wt(fast ? 50 : 1100);
    endtask : rbit
    task automatic wbyte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) wbit(v[i]);
    endtask : wbyte
endmodule : swr_master_model

// *** sim/swr_rom_layer_bench.sv ***
// self-checking bench for the single-wire rom layer
// the master model is the only other party on the line
`timescale 1ns/1ps
module swr_rom_layer_bench;
    import swr_pkg::*;
    localparam int RSTC = 3000;
    // identity value arbitrary
    localparam logic [63:0] ID = 64'ha5c3_0f1e_2d4b_6987;
    logic sys_clk;
    logic rst_n;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic line, dq, dq_oe, od, mstart, brst, ovr, rx_valid, tx_ready, p, b, c;
    logic [63:0] v;
    swr_byte_t rx_byte;
    int failures = 0;
    int checks = 0;
    int starts = 0;
    int resets = 0;
    always #25 sys_clk = !sys_clk;
    always @(posedge sys_clk) if (mstart === 1'b1) starts <= starts + 1;
    always @(posedge sys_clk) if (brst === 1'b1) resets <= resets + 1;
    swr_rom_layer #(.ROM_ID(ID), .RST_CYC(RSTC)) dut_u (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .dq_i(line), .dq_o(dq), .dq_oe_o(dq_oe),
        .overdrive_o(od), .bus_reset_o(brst), .mem_start_o(mstart), .rx_overrun_o(ovr),
        .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
        .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
    swr_master_model m_u (.sys_clk_i(sys_clk), .dev_pull_i(dq_oe), .line_o(line));
    ////////////////////////////////////////
    task automatic final_report;
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic pop(input logic [8:0] e);
        chk(rx_byte, e);
        rx_ready = 1'b1;
        m_u.wt(1);
        rx_ready = 1'b0;
    endtask : pop
    task automatic odrst;
        m_u.rst(1000, p);
        chk({p, od, ovr}, 3'b110);
    endtask : odrst
    task automatic t_skip_buffer;
        m_u.rst(RSTC, p);
        chk({p, dq, 30'(resets)}, {2'b10, 30'd1});
        m_u.wbyte(8'h3c);
        chk({od, 31'(starts)}, {1'b1, 31'd1});
        m_u.fast = 1'b1;
        m_u.wbyte(8'ha5);
        m_u.wbyte(8'h12);
        m_u.wbyte(8'h34);
        chk(ovr, 1'b1);
        pop({1'b1, 8'ha5});
        pop({1'b0, 8'h12});
        chk(rx_valid, 1'b0);
    endtask : t_skip_buffer
    task automatic t_read_rom;
        odrst;
        m_u.wbyte(8'h33);
        for (int i = 0; i < 64; i++) begin
            m_u.rbit(b);
            v[i] = b;
        end
        chk(v, ID);
        chk(starts, 2);
        tx_data = 8'h96;
        tx_valid = 1'b1;
        for (int n = 0; tx_ready !== 1'b1; n++) begin
            if (n == 8) begin
                failures++;
                final_report;
            end
            m_u.wt(1);
        end
        m_u.wt(1);
        tx_valid = 1'b0;
        for (int i = 0; i < 8; i++) begin
            m_u.rbit(b);
            v[i] = b;
        end
        chk({v[7:0], tx_ready}, {8'h96, 1'b1});
    endtask : t_read_rom
    task automatic t_match(input int bad);
        odrst;
        m_u.wbyte(8'h55);
        for (int i = 0; i < 64; i++) m_u.wbit(ID[i] ^ (i == bad));
        m_u.wbyte(8'h77);
        chk({rx_valid, 31'(starts)}, (bad < 64) ? 32'd2 : {1'b1, 31'd3});
        if (rx_valid === 1'b1) pop({1'b1, 8'h77});
    endtask : t_match
    task automatic t_search;
        odrst;
        m_u.wbyte(8'hf0);
        for (int i = 0; i < 5; i++) begin
            m_u.rbit(b);
            m_u.rbit(c);
            chk({b, c}, (i < 4) ? {ID[i], !ID[i]} : 2'b11);
            m_u.wbit(ID[i] ^ (i == 3));
        end
    endtask : t_search
    task automatic t_plain_skip;
        odrst;
        m_u.wbyte(8'h0f);
        m_u.wbyte(8'h77);
        chk({rx_valid, 31'(starts)}, 32'd3);
        odrst;
        m_u.wbyte(8'hcc);
        m_u.wbyte(8'h5a);
        chk({od, rx_valid, 30'(starts)}, {2'b11, 30'd4});
        pop({1'b1, 8'h5a});
    endtask : t_plain_skip
    task automatic t_od_match(input int bad);
        m_u.fast = 1'b0;
        m_u.rst(RSTC, p);
        chk({p, od}, 2'b10);
        m_u.wbyte(8'h69);
        chk(od, 1'b1);
        m_u.fast = 1'b1;
        for (int i = 0; i < 64; i++) m_u.wbit(ID[i] ^ (i == bad));
        chk({od, 31'(starts)}, (bad < 64) ? 32'd4 : {1'b1, 31'd5});
    endtask : t_od_match
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        rx_ready = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        t_skip_buffer;
        t_read_rom;
        t_match(63);
        t_match(64);
        t_search;
        t_plain_skip;
        t_od_match(5);
        t_od_match(64);
        final_report;
    end
    initial begin
        repeat (95000) @(posedge sys_clk);
        failures++;
        final_report;
    end
endmodule : swr_rom_layer_bench
